/* rtl/clkgen_map.svh */
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

// Register byte offsets
`define CG_ADDR_W 8
`define CG_OFS_CHIP_CFG 8'h00
`define CG_OFS_PIN_CFG 8'h04
`define CG_OFS_STATUS 8'h08

// chip_config_reg fields
`define CG_CHIP_DIV_LSB 0
`define CG_CHIP_DIV_MSB 1
`define CG_CHIP_DIV_RST 2'h0
`define CG_CHIP_MULT_LSB 2
`define CG_CHIP_MULT_MSB 4
`define CG_CHIP_AUDIO 5

// pin_config_reg fields
`define CG_PIN_CFG_W 10
`define CG_PIN_CFG_RST 10'h0FF
`define CG_PCI_OUTS 6
`define CG_PIN_SROM_EN 6
`define CG_PIN_DBG_EN 7
`define CG_PIN_PIO_OUT 8
`define CG_PIN_PIO_OE 9

// Status fields
`define CG_STAT_LOCK 0
`define CG_STAT_STRAP_DONE 1
`define CG_STAT_PIO_IN 2

// Divider phase steps: step per core cycle, modulus, high-half threshold
`define CG_PH_W 4
`define CG_STEP_2P5 4'h4
`define CG_MOD_2P5 4'hA
`define CG_HALF_2P5 4'h5
`define CG_STEP_3 4'h2
`define CG_MOD_3 4'h6
`define CG_HALF_3 4'h3
`define CG_STEP_5 4'h2
`define CG_MOD_5 4'hA
`define CG_HALF_5 4'h5
`define CG_STEP_6 4'h2
`define CG_MOD_6 4'hC
`define CG_HALF_6 4'h6

// Timing
`define CG_CLK_NS 100
`define CG_SROM_HALF_NS 500
`define CG_SROM_HALF_CYC ((`CG_SROM_HALF_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)
`define CG_SROM_CNT_W 4
`define CG_PLL_LOCK_EDGES 4
`define CG_PLL_LOSS_NS 2000
`define CG_PLL_LOSS_CYC (`CG_PLL_LOSS_NS / `CG_CLK_NS)
`define CG_PLL_LOSS_W 5
`define CG_TIMERS 3

`endif

/* rtl/clkgen_pkg.sv */
package clkgen_pkg;

   typedef enum logic [1:0] {
      DIV_2P5,
      DIV_3,
      DIV_5,
      DIV_6
   } pci_div_e;

   typedef enum logic [1:0] {
      BOOT_FILL0,
      BOOT_FILL1,
      BOOT_CAPTURE,
      BOOT_RUN
   } boot_state_e;

endpackage

/* rtl/pci_clock_divider.sv */
`timescale 1ns/1ps
`include "clkgen_map.svh"

module pci_clock_divider (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_clk_en,
   input wire clkgen_pkg::pci_div_e i_div_sel,
   output logic o_div_clk,
   output logic o_div_rise,
   output clkgen_pkg::pci_div_e o_div_active
);

   logic [`CG_PH_W-1:0] phase_q;
   logic [`CG_PH_W-1:0] phase_d;
   logic [`CG_PH_W-1:0] step;
   logic [`CG_PH_W-1:0] modv;
   logic [`CG_PH_W-1:0] half;
   logic [`CG_PH_W:0] sum;
   clkgen_pkg::pci_div_e active_q;
   logic clk_q;
   logic rise_q;

   // Fractional ratios come from a phase accumulator, so 2.5 averages exactly
   always_comb begin
      case (active_q)
         clkgen_pkg::DIV_2P5: begin
            step = `CG_STEP_2P5;
            modv = `CG_MOD_2P5;
            half = `CG_HALF_2P5;
         end
         clkgen_pkg::DIV_3: begin
            step = `CG_STEP_3;
            modv = `CG_MOD_3;
            half = `CG_HALF_3;
         end
         clkgen_pkg::DIV_5: begin
            step = `CG_STEP_5;
            modv = `CG_MOD_5;
            half = `CG_HALF_5;
         end
         clkgen_pkg::DIV_6: begin
            step = `CG_STEP_6;
            modv = `CG_MOD_6;
            half = `CG_HALF_6;
         end
         default: begin
            step = `CG_STEP_2P5;
            modv = `CG_MOD_2P5;
            half = `CG_HALF_2P5;
         end
      endcase
      sum = {1'b0, phase_q} + {1'b0, step};
      if (sum >= {1'b0, modv}) begin
         phase_d = sum[`CG_PH_W-1:0] - modv;
      end else begin
         phase_d = sum[`CG_PH_W-1:0];
      end
   end

   // Ratio only switches at a period boundary to avoid a runt pulse
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         phase_q <= '0;
         active_q <= clkgen_pkg::DIV_2P5;
         clk_q <= 1'b0;
         rise_q <= 1'b0;
      end else if (i_clk_en) begin
         phase_q <= phase_d; // RULE_01
         clk_q <= (phase_d < half); // RULE_04
         rise_q <= (phase_d < half) & ~clk_q;
         if (phase_d == '0) begin
            active_q <= i_div_sel;
         end
      end
   end

   assign o_div_clk = clk_q;
   assign o_div_rise = rise_q;
   assign o_div_active = active_q;

   a_div_three_period: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_01
      (rise_q && active_q == clkgen_pkg::DIV_3 && i_clk_en) ##1 i_clk_en [*2] |=> rise_q)
      else $error("divide by 3 period is not 3 cycles");

   a_div_six_period: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_01
      (rise_q && active_q == clkgen_pkg::DIV_6 && i_clk_en) ##1 i_clk_en [*5] |=> rise_q)
      else $error("divide by 6 period is not 6 cycles");

endmodule

/* rtl/pci_and_peripheral_clock_gen.sv */
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "clkgen_map.svh"

// Behaviour
// (RULE_01) PCI clocks are core clock divided by 2.5, 3, 5 or 6 per select.
// (RULE_02) Divide select comes from boot straps or the software chip config field.
// (RULE_03) Six per-output enables in pin config; cleared enable holds that output low.
// (RULE_04) Suitable select yields 66 or 33 MHz from 200 or 166.7 MHz core.
// (RULE_05) Internal PCI controller clock is taken from the PCI clock input pin.
// (RULE_06) Second PLL tracks the PCI input in frequency and phase; the model's controller clock lags the pin by three flop stages.
// (RULE_07) Board feeds PCI clock input from our output or another agent.
// (RULE_08) A serial clock is driven to the configuration serial memory.
// (RULE_09) One external serial clock input feeds both serial channels.
// (RULE_10) One external timer clock input feeds all three timers.
// (RULE_11) Audio bit clock shares parallel I/O line 2; strap selects function.
// (RULE_12) A dedicated debug trace clock output is driven.
// (RULE_13) First PLL ratio 2 to 16 is chosen by three boot straps.
// (RULE_14) Straps latch at reset release into divide field until software rewrites.
module pci_and_peripheral_clock_gen (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_clk_en,
   input wire logic [`CG_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [1:0] i_boot_addr_div,
   input wire logic i_boot_addr_audio,
   input wire logic [2:0] i_boot_addr_mult,
   input wire logic i_pci_clock_in,
   input wire logic i_serial_ext_clock,
   input wire logic i_timer_ext_clock,
   input wire logic i_pio2_in,
   output logic o_pio2_out,
   output logic o_pio2_oe,
   output logic [`CG_PCI_OUTS-1:0] o_pci_clock_out,
   output logic o_pci_core_clock,
   output logic o_second_pll_locked,
   output logic [2:0] o_first_pll_ratio,
   output logic o_serial_rom_clock,
   output logic o_serial_channel_0_clock,
   output logic o_serial_channel_1_clock,
   output logic [`CG_TIMERS-1:0] o_timer_clock,
   output logic o_audio_link_bit_clock,
   output logic o_parallel_io_line_2,
   output logic o_debug_trace_clock
);

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);

   logic [9:0] sync1_q;
   logic [9:0] sync2_q;
   logic [1:0] strap_div;
   logic strap_audio;
   logic [2:0] strap_mult;
   logic pci_in_s;
   logic serial_s;
   logic timer_s;
   logic pio_s;

   // Every pin and strap passes two flops before anything looks at it
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (i_clk_en) begin
         sync1_q <= {i_boot_addr_div, i_boot_addr_audio, i_boot_addr_mult,
                     i_pci_clock_in, i_serial_ext_clock, i_timer_ext_clock, i_pio2_in};
         sync2_q <= sync1_q;
      end
   end

   assign strap_div = sync2_q[9:8];
   assign strap_audio = sync2_q[7];
   assign strap_mult = sync2_q[6:4];
   assign pci_in_s = sync2_q[3];
   assign serial_s = sync2_q[2];
   assign timer_s = sync2_q[1];
   assign pio_s = sync2_q[0];

   // Strap capture waits until the synchroniser holds post-reset pin levels
   clkgen_pkg::boot_state_e boot_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         boot_q <= clkgen_pkg::BOOT_FILL0;
      end else if (i_clk_en) begin
         case (boot_q)
            clkgen_pkg::BOOT_FILL0: boot_q <= clkgen_pkg::BOOT_FILL1;
            clkgen_pkg::BOOT_FILL1: boot_q <= clkgen_pkg::BOOT_CAPTURE;
            clkgen_pkg::BOOT_CAPTURE: boot_q <= clkgen_pkg::BOOT_RUN;
            clkgen_pkg::BOOT_RUN: boot_q <= clkgen_pkg::BOOT_RUN;
            default: boot_q <= clkgen_pkg::BOOT_RUN;
         endcase
      end
   end

   logic wr_chip;
   logic wr_pin;
   logic strap_done;

   assign wr_chip = i_wr && (i_addr == `CG_OFS_CHIP_CFG);
   assign wr_pin = i_wr && (i_addr == `CG_OFS_PIN_CFG);
   assign strap_done = (boot_q == clkgen_pkg::BOOT_RUN);

   // chip_config_reg
   clkgen_pkg::pci_div_e div_sel_q;
   logic [2:0] mult_q;
   logic audio_sel_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         div_sel_q <= clkgen_pkg::pci_div_e'(`CG_CHIP_DIV_RST);
         mult_q <= '0;
         audio_sel_q <= 1'b0;
      end else if (i_clk_en) begin
         if (boot_q == clkgen_pkg::BOOT_CAPTURE) begin
            div_sel_q <= clkgen_pkg::pci_div_e'(strap_div); // RULE_14
            mult_q <= strap_mult; // RULE_13
            audio_sel_q <= strap_audio; // RULE_11
         end else if (strap_done && wr_chip) begin
            div_sel_q <= clkgen_pkg::pci_div_e'(i_wdata[`CG_CHIP_DIV_MSB:`CG_CHIP_DIV_LSB]); // RULE_02
         end
      end
   end

   // pin_config_reg
   logic [`CG_PIN_CFG_W-1:0] pin_cfg_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_cfg_q <= `CG_PIN_CFG_RST;
      end else if (i_clk_en && wr_pin) begin
         pin_cfg_q <= i_wdata[`CG_PIN_CFG_W-1:0];
      end
   end

   // PCI output clocks
   logic div_clk;
   logic div_rise;
   clkgen_pkg::pci_div_e div_active;

   pci_clock_divider u_pci_div (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_clk_en(i_clk_en),
      .i_div_sel(div_sel_q),
      .o_div_clk(div_clk),
      .o_div_rise(div_rise),
      .o_div_active(div_active)
   );

   for (genvar g = 0; g < `CG_PCI_OUTS; g++) begin : g_pci_out
      logic out_q;
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
         if (!i_rstn) begin
            out_q <= 1'b0;
         end else if (i_clk_en) begin
            out_q <= div_clk & pin_cfg_q[g]; // RULE_03
         end
      end
      assign o_pci_clock_out[g] = out_q;
   end

   // Second PLL model: lock after a run of input edges, drop on a silent input.
   // The sampled copy trails the pin by the synchroniser delay; a real PLL hides that.
   logic pci_prev_q;
   logic pci_rise;
   logic [2:0] lock_cnt_q;
   logic [`CG_PLL_LOSS_W-1:0] quiet_cnt_q;
   logic locked_q;
   logic core_clk_q;
   logic quiet_max;

   assign pci_rise = pci_in_s & ~pci_prev_q;
   assign quiet_max = (quiet_cnt_q == `CG_PLL_LOSS_W'(`CG_PLL_LOSS_CYC));

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pci_prev_q <= 1'b0;
         quiet_cnt_q <= '0;
      end else if (i_clk_en) begin
         pci_prev_q <= pci_in_s;
         if (pci_rise) begin
            quiet_cnt_q <= '0;
         end else if (!quiet_max) begin
            quiet_cnt_q <= quiet_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lock_cnt_q <= '0;
         locked_q <= 1'b0;
      end else if (i_clk_en) begin
         if (quiet_max) begin
            lock_cnt_q <= '0;
            locked_q <= 1'b0;
         end else if (pci_rise && !locked_q) begin
            if (lock_cnt_q == 3'(`CG_PLL_LOCK_EDGES - 1)) begin
               locked_q <= 1'b1; // RULE_06
            end else begin
               lock_cnt_q <= lock_cnt_q + 1'b1;
            end
         end
      end
   end

   // The controller clock follows the input pin, which the board wires back (RULE_07)
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         core_clk_q <= 1'b0;
      end else if (i_clk_en) begin
         core_clk_q <= locked_q & pci_in_s; // RULE_05
      end
   end

   // Serial configuration memory clock
   logic [`CG_SROM_CNT_W-1:0] srom_cnt_q;
   logic srom_clk_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         srom_cnt_q <= '0;
         srom_clk_q <= 1'b0;
      end else if (i_clk_en) begin
         if (!pin_cfg_q[`CG_PIN_SROM_EN]) begin
            srom_cnt_q <= '0;
            srom_clk_q <= 1'b0;
         end else if (srom_cnt_q == `CG_SROM_CNT_W'(`CG_SROM_HALF_CYC - 1)) begin
            srom_cnt_q <= '0;
            srom_clk_q <= ~srom_clk_q; // RULE_08
         end else begin
            srom_cnt_q <= srom_cnt_q + 1'b1;
         end
      end
   end

   // Debug trace clock: half the core rate
   logic dbg_clk_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         dbg_clk_q <= 1'b0;
      end else if (i_clk_en) begin
         dbg_clk_q <= pin_cfg_q[`CG_PIN_DBG_EN] & ~dbg_clk_q; // RULE_12
      end
   end

   // Shared external clocks fan out from one sampled source
   logic ser0_q;
   logic ser1_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ser0_q <= 1'b0;
         ser1_q <= 1'b0;
      end else if (i_clk_en) begin
         ser0_q <= serial_s; // RULE_09
         ser1_q <= serial_s; // RULE_09
      end
   end

   for (genvar t = 0; t < `CG_TIMERS; t++) begin : g_timer
      logic tmr_q;
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
         if (!i_rstn) begin
            tmr_q <= 1'b0;
         end else if (i_clk_en) begin
            tmr_q <= timer_s; // RULE_10
         end
      end
      assign o_timer_clock[t] = tmr_q;
   end

   // Shared pin: audio bit clock input, or parallel I/O line 2
   logic audio_clk_q;
   logic pio_data_q;
   logic pio_out_q;
   logic pio_oe_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         audio_clk_q <= 1'b0;
         pio_data_q <= 1'b0;
         pio_out_q <= 1'b0;
         pio_oe_q <= 1'b0;
      end else if (i_clk_en) begin
         audio_clk_q <= audio_sel_q & pio_s; // RULE_11
         pio_data_q <= ~audio_sel_q & pio_s;
         pio_out_q <= pin_cfg_q[`CG_PIN_PIO_OUT];
         pio_oe_q <= ~audio_sel_q & pin_cfg_q[`CG_PIN_PIO_OE]; // RULE_11
      end
   end

   // Register read: data stand only in the cycle after the strobe
   logic [31:0] rdata_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= '0;
      end else if (i_clk_en) begin
         rdata_q <= '0;
         if (i_rd) begin
            case (i_addr)
               `CG_OFS_CHIP_CFG: begin
                  rdata_q[`CG_CHIP_DIV_MSB:`CG_CHIP_DIV_LSB] <= div_sel_q;
                  rdata_q[`CG_CHIP_MULT_MSB:`CG_CHIP_MULT_LSB] <= mult_q;
                  rdata_q[`CG_CHIP_AUDIO] <= audio_sel_q;
               end
               `CG_OFS_PIN_CFG: rdata_q[`CG_PIN_CFG_W-1:0] <= pin_cfg_q;
               `CG_OFS_STATUS: begin
                  rdata_q[`CG_STAT_LOCK] <= locked_q;
                  rdata_q[`CG_STAT_STRAP_DONE] <= strap_done;
                  rdata_q[`CG_STAT_PIO_IN] <= pio_s;
               end
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign o_rdata = rdata_q;
   assign o_pio2_out = pio_out_q;
   assign o_pio2_oe = pio_oe_q;
   assign o_pci_core_clock = core_clk_q;
   assign o_second_pll_locked = locked_q;
   assign o_first_pll_ratio = mult_q;
   assign o_serial_rom_clock = srom_clk_q;
   assign o_serial_channel_0_clock = ser0_q;
   assign o_serial_channel_1_clock = ser1_q;
   assign o_audio_link_bit_clock = audio_clk_q;
   assign o_parallel_io_line_2 = pio_data_q;
   assign o_debug_trace_clock = dbg_clk_q;

   a_pci_out_gated: assert property ( // RULE_03
      (i_clk_en && !pin_cfg_q[0]) |=> !o_pci_clock_out[0])
      else $error("disabled PCI clock output toggled");

   a_strap_loads_div: assert property ( // RULE_14
      (i_clk_en && boot_q == clkgen_pkg::BOOT_CAPTURE) |=> (div_sel_q == $past(strap_div)))
      else $error("boot strap not latched into divide select");

   a_sw_sets_div: assert property ( // RULE_02
      (i_clk_en && strap_done && wr_chip) |=> (div_sel_q == $past(i_wdata[1:0])))
      else $error("software divide select not applied");

   a_core_needs_lock: assert property ( // RULE_05
      (i_clk_en && !locked_q) |=> !o_pci_core_clock)
      else $error("PCI controller clock runs before lock");

   a_core_follows_pin: assert property ( // RULE_06
      (i_clk_en && locked_q && pci_in_s) ##1 (i_clk_en && locked_q) |-> o_pci_core_clock)
      else $error("PCI controller clock does not follow the input");

   a_serial_shared: assert property ( // RULE_09
      i_clk_en |=> (o_serial_channel_0_clock == $past(serial_s)) && (o_serial_channel_1_clock == $past(serial_s)))
      else $error("serial channels see different clocks");

   a_timer_shared: assert property ( // RULE_10
      i_clk_en |=> (o_timer_clock == {`CG_TIMERS{$past(timer_s)}}))
      else $error("timers do not share the external clock");

   a_audio_no_drive: assert property ( // RULE_11
      audio_sel_q |=> !o_pio2_oe)
      else $error("shared pin driven in audio mode");

   a_srom_half: assert property ( // RULE_08
      (i_clk_en && pin_cfg_q[`CG_PIN_SROM_EN] && srom_cnt_q == `CG_SROM_CNT_W'(`CG_SROM_HALF_CYC - 1))
      |=> (o_serial_rom_clock != $past(o_serial_rom_clock)))
      else $error("serial memory clock missed its half period");

   a_debug_toggle: assert property ( // RULE_12
      (i_clk_en && pin_cfg_q[`CG_PIN_DBG_EN]) |=> (o_debug_trace_clock != $past(o_debug_trace_clock)))
      else $error("debug clock did not toggle");

   a_ratio_strap: assert property ( // RULE_13
      (i_clk_en && boot_q == clkgen_pkg::BOOT_CAPTURE) |=> (o_first_pll_ratio == $past(strap_mult)))
      else $error("first PLL ratio not taken from straps");

   c_div_2p5: cover property (div_rise && div_active == clkgen_pkg::DIV_2P5);
   c_div_6: cover property (div_rise && div_active == clkgen_pkg::DIV_6);
   c_pll_lock: cover property ($rose(locked_q));
   c_audio_mode: cover property (audio_sel_q && o_audio_link_bit_clock);

endmodule

/* verif/pci_board_model.sv */
`timescale 1ns/1ps

module pci_board_model (
   input wire logic i_clk_sys,
   input wire logic [5:0] i_pci_clock_out,
   input wire logic i_src_agent,
   input wire logic i_run,
   output logic o_pci_clock_in
);
   // Another agent's clock, period of four core cycles, unrelated to our divider
   logic [1:0] agent_q = 2'h0;

   always @(posedge i_clk_sys) begin
      agent_q <= agent_q + 2'h1;
   end

   // Feedback wire from our output 0 or from the other agent; stands low when stopped
   assign o_pci_clock_in = i_run & (i_src_agent ? agent_q[1] : i_pci_clock_out[0]);
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`include "clkgen_map.svh"

module tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] rdata;
   logic [1:0] boot_div = 2'h0;
   logic boot_audio = 1'b0;
   logic [2:0] boot_mult = 3'h0;
   logic pci_in, ser_clk = 1'b0, tmr_clk = 1'b0, pio_in = 1'b0;
   logic src_agent = 1'b0, run = 1'b0;
   logic pio_out, pio_oe, core_clk, locked, rom_clk, ser0_clk, ser1_clk, audio_clk, pio_line, dbg_clk;
   logic [5:0] pci_out;
   logic [2:0] ratio, tmr_out;
   int miscompares = 0;
   int n_checks = 0;
   int c;
   int exp_r[4] = '{24, 20, 12, 10};

   always #50 clk_sys = ~clk_sys;

   pci_and_peripheral_clock_gen i_dut (
      .i_clk_sys(clk_sys), .i_rstn(rstn), .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata), .i_boot_addr_div(boot_div),
      .i_boot_addr_audio(boot_audio), .i_boot_addr_mult(boot_mult), .i_pci_clock_in(pci_in),
      .i_serial_ext_clock(ser_clk), .i_timer_ext_clock(tmr_clk), .i_pio2_in(pio_in),
      .o_pio2_out(pio_out), .o_pio2_oe(pio_oe), .o_pci_clock_out(pci_out), .o_pci_core_clock(core_clk),
      .o_second_pll_locked(locked), .o_first_pll_ratio(ratio), .o_serial_rom_clock(rom_clk),
      .o_serial_channel_0_clock(ser0_clk), .o_serial_channel_1_clock(ser1_clk), .o_timer_clock(tmr_out),
      .o_audio_link_bit_clock(audio_clk), .o_parallel_io_line_2(pio_line), .o_debug_trace_clock(dbg_clk)
   );

   pci_board_model i_board (
      .i_clk_sys(clk_sys), .i_pci_clock_out(pci_out), .i_src_agent(src_agent), .i_run(run),
      .o_pci_clock_in(pci_in)
   );

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken just after that edge
   task automatic reg_expect(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      @(posedge clk_sys);
      addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 d = rdata;
      check(n, d & m, e);
   endtask

   function automatic logic pick(input int s);
      logic [9:0] v;
      v = {pci_in, dbg_clk, rom_clk, core_clk, pci_out};
      return v[s];
   endfunction

   // Sixty cycles is a whole number of periods of every clock counted here
   task automatic count_rises(input int s, output int n);
      logic prev, cur;
      n = 0;
      @(posedge clk_sys);
      #1 prev = pick(s);
      repeat (60) begin
         @(posedge clk_sys);
         #1 cur = pick(s);
         if (cur === 1'b1 && prev === 1'b0) n++;
         prev = cur;
      end
   endtask

   task automatic do_reset(input logic [1:0] d, input logic au, input logic [2:0] m);
      @(posedge clk_sys);
      rstn <= 1'b0;
      run <= 1'b0;
      boot_div <= d;
      boot_audio <= au;
      boot_mult <= m;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      // Too early: straps not yet captured, so this write must be lost
      reg_write(`CG_OFS_CHIP_CFG, 32'h3);
      repeat (6) @(posedge clk_sys);
      reg_expect("chip_cfg", `CG_OFS_CHIP_CFG, 32'h3F, {26'h0, au, m, d});
      check("pll_ratio", ratio, m);
      reg_expect("pin_cfg_rst", `CG_OFS_PIN_CFG, 32'hFFFFFFFF, 32'h0FF);
   endtask

   task automatic pll_run(input logic agent, input int n);
      @(posedge clk_sys);
      src_agent <= agent;
      run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      check("pll_locked", locked, 1'b1);
      count_rises(6, c);
      check("core_clk_rises", c, n);
      @(posedge clk_sys);
      run <= 1'b0;
      repeat (30) @(posedge clk_sys);
      check("pll_unlocked", locked, 1'b0);
      count_rises(6, c);
      check("core_clk_stopped", c, 0);
   endtask

   initial begin
      #(100 * 20000);
      miscompares++;
      final_report();
   end

   initial begin
      do_reset(2'h2, 1'b1, 3'h5);
      reg_expect("strap_done", `CG_OFS_STATUS, 32'h2, 32'h2);
      count_rises(0, c);
      check("strap_div5", c, 12);
      count_rises(7, c);
      check("rom_clk_rises", c, 6);
      count_rises(8, c);
      check("dbg_clk_rises", c, 30);
      pll_run(1'b0, 12);
      @(posedge clk_sys);
      pio_in <= 1'b1;
      reg_write(`CG_OFS_PIN_CFG, 32'h3FF);
      repeat (5) @(posedge clk_sys);
      check("audio_mode", {audio_clk, pio_line, pio_oe}, 3'b100);
      pio_in <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check("audio_low", audio_clk, 1'b0);
      do_reset(2'h1, 1'b0, 3'h2);
      @(posedge clk_sys);
      pio_in <= 1'b1;
      reg_write(`CG_OFS_PIN_CFG, 32'h3FF);
      repeat (5) @(posedge clk_sys);
      check("pio_mode", {pio_line, audio_clk, pio_oe, pio_out}, 4'b1011);
      reg_expect("pin_sample", `CG_OFS_STATUS, 32'h4, 32'h4);
      reg_write(`CG_OFS_PIN_CFG, 32'h0FF);
      repeat (3) @(posedge clk_sys);
      check("pio_released", pio_oe, 1'b0);
      pll_run(1'b1, 15);
      for (int v = 1; v >= 0; v--) begin
         @(posedge clk_sys);
         ser_clk <= 1'(v);
         tmr_clk <= 1'(v);
         repeat (5) @(posedge clk_sys);
         check("shared_clk", {ser0_clk, ser1_clk, tmr_out}, v ? 32'h1F : 32'h0);
      end
      for (int s = 0; s < 4; s++) begin
         reg_write(`CG_OFS_CHIP_CFG, 32'hFFFFFFFC | 32'(s));
         repeat (12) @(posedge clk_sys);
         count_rises(0, c);
         check("pci_div_rises", c, exp_r[s]);
         reg_expect("chip_cfg_div", `CG_OFS_CHIP_CFG, 32'h3F, {26'h0, 1'b0, 3'h2, 2'(s)});
      end
      for (int k = 0; k < 6; k++) begin
         reg_write(`CG_OFS_PIN_CFG, 32'h0FF & ~(32'h1 << k));
         repeat (3) @(posedge clk_sys);
         count_rises(k, c);
         check("pci_out_off", c, 0);
         count_rises((k + 1) % 6, c);
         check("pci_out_on", c, 10);
      end
      reg_write(`CG_OFS_PIN_CFG, 32'h03F);
      count_rises(7, c);
      check("rom_clk_off", c, 0);
      count_rises(8, c);
      check("dbg_clk_off", c, 0);
      reg_write(8'h0C, 32'hFFFFFFFF);
      reg_expect("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
      reg_write(`CG_OFS_STATUS, 32'h0);
      reg_expect("status_ro", `CG_OFS_STATUS, 32'h2, 32'h2);
      final_report();
   end
endmodule
